//--- hw/region_protection_unit_regs.sv
// region protection unit: registers, eight unified regions, access checker
// assumes exclusive read/write strobes from the core, checks one access a cycle
`timescale 1ns/10ps
`default_nettype none
// Function
// - capability instruction-region count reads zero
// - capability data-region count reads eight
// - capability split-map flag reads zero
// - enabled, no background: miss of all enabled regions faults
// - enabled with background: privileged misses use default map below all regions
// - disabled: default map for everyone, background bit ignored
// - handler bit clear bypasses checks in escalated handlers; set keeps them
// - enabled with background: unprivileged miss faults
// - system control space is always no-execute and strongly ordered
// - enabled: system control space data accesses and vector table always permitted
// - selector picks one of eight regions, values zero to seven
// - base write, update-select clear: selector kept, base to current region
// - base write, update-select set: selector loaded, base to new region
// - base read: update-select zero, region field shows selector
// - base field is bits 31 down to N, aligned to region size
// - 4 GB region ignores base and covers whole map
// - attribute register takes word or halfword; attributes high, size low
// - no-execute set refuses fetches, clear allows them
// - each subregion mask bit disables its subregion when set
// - region size is two to size plus one, minimum 32 bytes
// - regions of 256 bytes up split in eight, low bit lowest
// - disabled subregion falls to another region or else is handled as a miss
// - permission violation faults and records cause in status
module region_protection_unit_regs
   import rpu_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [3:0]  reg_be,
   input  wire logic [31:0] reg_wdata,
   output logic [31:0]      reg_rdata,
   output logic             reg_rvalid,
   // checked access
   input  wire logic        chk_valid,
   input  wire logic [31:0] chk_addr,
   input  wire logic        chk_priv,
   input  wire logic        chk_fetch,
   input  wire logic        chk_write,
   input  wire logic        chk_vector,
   input  wire logic        chk_escalated,
   // check result
   output logic             chk_done,
   output logic             chk_fault,
   output logic             chk_hit,
   output region_idx_t      chk_region,
   output logic [5:0]       chk_attr,
   output logic             chk_strong_order,
   // fault status
   input  wire logic [1:0]  fault_clear,
   output logic             fault_iaccess,
   output logic             fault_daccess,
   output logic [31:0]      fault_addr
);
`include "rpu_consts.svh"

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic        ctl_enable;
   logic        ctl_handler;
   logic        ctl_background;
   region_idx_t region_sel;
   logic [26:0] base_addr [8];
   logic [31:0] attr_word [8];
   logic [7:0]  hits;

   logic        wr_base;
   logic        wr_attr;
   logic        rd_base;
   region_idx_t base_target;
   logic [31:0] next_rdata;
   logic [31:0] cap_word;
   logic [31:0] attr_merge;

   assign wr_base = reg_wr && (reg_addr == `OFS_BASE || reg_addr == `OFS_BASE_A1);
   assign wr_attr = reg_wr && (reg_addr == `OFS_ATTR || reg_addr == `OFS_ATTR_A1);
   assign rd_base = reg_rd && (reg_addr == `OFS_BASE || reg_addr == `OFS_BASE_A1);
   // update-select picks the written field, else the current selector
   assign base_target = reg_wdata[`BASE_UPDSEL_BIT] ? region_idx_t'(reg_wdata[2:0])
                                                    : region_sel;
   assign cap_word = {8'h00, `CAP_IREG_VAL, `CAP_DREG_VAL, 7'h00, `CAP_SPLIT_VAL};

   // byte lanes: halfword writes land on their own half only
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         attr_merge[b*8 +: 8] = reg_be[b] ? reg_wdata[b*8 +: 8]
                                          : attr_word[region_sel][b*8 +: 8];
      end
   end

   // ----------------------------------------
   // control register
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         {ctl_background, ctl_handler, ctl_enable} <= `CTL_RESET;
      end else if (reg_wr && reg_addr == `OFS_CONTROL) begin
         ctl_enable     <= reg_wdata[`CTL_ENABLE_BIT];
         ctl_handler    <= reg_wdata[`CTL_HANDLER_BIT];
         ctl_background <= reg_wdata[`CTL_BACKGROUND_BIT];
      end
   end

   // ----------------------------------------
   // region selector
   // ----------------------------------------
   // only three bits held, so values above seven cannot be stored
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         region_sel <= `SEL_RESET;
      end else if (reg_wr && reg_addr == `OFS_SELECTOR) begin
         region_sel <= region_idx_t'(reg_wdata[2:0]);
      end else if (wr_base && reg_wdata[`BASE_UPDSEL_BIT]) begin
         region_sel <= region_idx_t'(reg_wdata[2:0]);
      end
   end

   // ----------------------------------------
   // region storage
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int r = 0; r < 8; r++) begin
            base_addr[r] <= 27'h000_0000;
            attr_word[r] <= `ATTR_RESET;
         end
      end else begin
         if (wr_base) begin
            base_addr[base_target] <= reg_wdata[31:`BASE_LSB];
         end
         if (wr_attr) begin
            attr_word[region_sel] <= attr_merge & `ATTR_WMASK;
         end
      end
   end

   // ----------------------------------------
   // register read
   // ----------------------------------------
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (reg_addr)
         `OFS_CAPABILITY: next_rdata = cap_word;
         `OFS_CONTROL:    next_rdata = {29'h0000_0000, ctl_background, ctl_handler, ctl_enable};
         `OFS_SELECTOR:   next_rdata = {29'h0000_0000, region_sel};
         `OFS_BASE, `OFS_BASE_A1:
            next_rdata = {base_addr[region_sel], 2'h0, region_sel};
         `OFS_ATTR, `OFS_ATTR_A1:
            next_rdata = attr_word[region_sel];
         default:         next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata  <= 32'h0000_0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         reg_rdata  <= reg_rd ? next_rdata : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // region matchers
   // ----------------------------------------
   for (genvar g = 0; g < 8; g++) begin : g_region
      region_match u_match (
         .base   (base_addr[g]),
         .size   (attr_word[g][`ATTR_SIZE_LSB +: 5]),
         .subregion_disable_mask    (attr_word[g][`ATTR_SRD_LSB +: 8]),
         .enable (attr_word[g][`ATTR_EN_BIT]),
         .addr   (chk_addr),
         .hit    (hits[g])
      );
   end

   // ----------------------------------------
   // access decision
   // ----------------------------------------
   logic        any_hit;
   region_idx_t win;
   logic [31:0] win_attr;
   logic        in_scs;
   logic        checking;
   perm_t       perm;
   logic        next_fault;
   logic        next_hit;

   // later index overrides earlier, so the highest-numbered match wins
   always_comb begin
      any_hit = 1'b0;
      win     = 3'h0;
      for (int r = 0; r < 8; r++) begin
         if (hits[r]) begin
            any_hit = 1'b1;
            win     = region_idx_t'(r);
         end
      end
   end

   assign win_attr = attr_word[win];
   assign in_scs   = (chk_addr >= `SCS_FIRST) && (chk_addr <= `SCS_LAST);
   // escalated handlers skip checks unless handler protection is set
   assign checking = ctl_enable && !(chk_escalated && !ctl_handler);

   always_comb begin
      case (win_attr[`ATTR_PERM_LSB +: 3])
         3'h1:    perm = chk_priv ? perm_rw : perm_none;
         3'h2:    perm = chk_priv ? perm_rw : perm_read;
         3'h3:    perm = perm_rw;
         3'h5:    perm = chk_priv ? perm_read : perm_none;
         3'h6:    perm = perm_read;
         3'h7:    perm = perm_read;
         default: perm = perm_none;
      endcase
   end

   always_comb begin
      next_fault = 1'b0;
      next_hit   = 1'b0;
      if (in_scs) begin
         // fetches refused here even with the unit off
         next_fault = chk_fetch;
      end else if (chk_vector && ctl_enable) begin
         next_fault = 1'b0;
      end else if (!checking) begin
         next_fault = 1'b0;
      end else if (any_hit) begin
         next_hit   = 1'b1;
         next_fault = (perm == perm_none) || (chk_write && perm != perm_rw)
                   || (chk_fetch && win_attr[`ATTR_XN_BIT]);
      end else begin
         // miss, including a disabled subregion with no other cover
         next_fault = !(ctl_background && chk_priv);
      end
   end

   // ----------------------------------------
   // check result
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         chk_done         <= 1'b0;
         chk_fault        <= 1'b0;
         chk_hit          <= 1'b0;
         chk_region       <= 3'h0;
         chk_attr         <= 6'h00;
         chk_strong_order <= 1'b0;
      end else begin
         chk_done         <= chk_valid;
         chk_fault        <= chk_valid && next_fault;
         chk_hit          <= chk_valid && next_hit;
         chk_region       <= (chk_valid && next_hit) ? win : 3'h0;
         chk_attr         <= (chk_valid && next_hit) ? win_attr[`ATTR_BCS_LSB +: 6] : 6'h00;
         chk_strong_order <= chk_valid && in_scs;
      end
   end

   // ----------------------------------------
   // fault status
   // ----------------------------------------
   // new fault beats a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fault_iaccess <= 1'b0;
         fault_daccess <= 1'b0;
         fault_addr    <= 32'h0000_0000;
      end else begin
         fault_iaccess <= (chk_valid && next_fault && chk_fetch)
                       || (fault_iaccess && !fault_clear[0]);
         fault_daccess <= (chk_valid && next_fault && !chk_fetch)
                       || (fault_daccess && !fault_clear[1]);
         if (chk_valid && next_fault) begin
            fault_addr <= chk_addr;
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_cap_instr_region_count;
      @(posedge clk_sys) disable iff (rst)
      reg_rd && reg_addr == `OFS_CAPABILITY |=> reg_rdata[23:16] == 8'h00;
   endproperty
   a_cap_instr_region_count: assert property (p_cap_instr_region_count) else $error("instr_region_count not zero");

   property p_cap_data_region_count;
      @(posedge clk_sys) disable iff (rst)
      reg_rd && reg_addr == `OFS_CAPABILITY |=> reg_rvalid && reg_rdata[15:8] == 8'h08;
   endproperty
   a_cap_data_region_count: assert property (p_cap_data_region_count) else $error("data_region_count not eight");

   property p_cap_split;
      @(posedge clk_sys) disable iff (rst)
      reg_rd && reg_addr == `OFS_CAPABILITY |=> !reg_rdata[0];
   endproperty
   a_cap_split: assert property (p_cap_split) else $error("split flag set");

   property p_sel_kept;
      @(posedge clk_sys) disable iff (rst)
      wr_base && !reg_wdata[`BASE_UPDSEL_BIT] |=> $stable(region_sel);
   endproperty
   a_sel_kept: assert property (p_sel_kept) else $error("selector moved");

   property p_sel_loaded;
      @(posedge clk_sys) disable iff (rst)
      wr_base && reg_wdata[`BASE_UPDSEL_BIT]
      |=> region_sel == $past(reg_wdata[2:0]) && base_addr[region_sel] == $past(reg_wdata[31:5]);
   endproperty
   a_sel_loaded: assert property (p_sel_loaded) else $error("selector not loaded");

   property p_base_read;
      @(posedge clk_sys) disable iff (rst)
      rd_base |=> !reg_rdata[4] && reg_rdata[2:0] == $past(region_sel);
   endproperty
   a_base_read: assert property (p_base_read) else $error("base read fields wrong");

   property p_reset_off;
      @(posedge clk_sys)
      rst |=> !ctl_enable && !ctl_background && !ctl_handler && !attr_word[0][0];
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("enable after reset");

   property p_disabled_open;
      @(posedge clk_sys) disable iff (rst)
      chk_valid && !ctl_enable && !in_scs |=> chk_done && !chk_fault;
   endproperty
   a_disabled_open: assert property (p_disabled_open) else $error("fault while off");

   property p_scs_fetch;
      @(posedge clk_sys) disable iff (rst)
      chk_valid && chk_fetch && in_scs |=> chk_fault && chk_strong_order;
   endproperty
   a_scs_fetch: assert property (p_scs_fetch) else $error("scs fetch allowed");

   property p_unpriv_miss;
      @(posedge clk_sys) disable iff (rst)
      chk_valid && checking && ctl_background && !chk_priv && !any_hit && !in_scs
      && !chk_vector |=> chk_fault && (fault_iaccess || fault_daccess);
   endproperty
   a_unpriv_miss: assert property (p_unpriv_miss) else $error("unpriv miss passed");

endmodule
`default_nettype wire

//--- inc/rpu_consts.svh
// constants for the region protection unit: offsets, field positions, reset values
// assumes byte offsets on the documented register port, 32-bit data words
`ifndef RPU_CONSTS_SVH
`define RPU_CONSTS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFS_CAPABILITY      8'h00
`define OFS_CONTROL         8'h04
`define OFS_SELECTOR        8'h08
`define OFS_BASE            8'h0C
`define OFS_ATTR            8'h10
`define OFS_BASE_A1         8'h14
`define OFS_ATTR_A1         8'h18

// ----------------------------------------
// capability fields
// ----------------------------------------
`define CAP_IREG_LSB        16
`define CAP_IREG_VAL        8'h00
`define CAP_DREG_LSB        8
`define CAP_DREG_VAL        8'h08
`define CAP_SPLIT_BIT       0
`define CAP_SPLIT_VAL       1'b0

// ----------------------------------------
// control fields, reset value
// ----------------------------------------
`define CTL_ENABLE_BIT      0
`define CTL_HANDLER_BIT     1
`define CTL_BACKGROUND_BIT  2
`define CTL_RESET           3'h0

// ----------------------------------------
// base address fields
// ----------------------------------------
`define BASE_UPDSEL_BIT     4
`define BASE_LSB            5
`define SEL_RESET           3'h0

// ----------------------------------------
// attribute and size fields
// ----------------------------------------
`define ATTR_EN_BIT         0
`define ATTR_SIZE_LSB       1
`define ATTR_SRD_LSB        8
`define ATTR_BCS_LSB        16
`define ATTR_TEX_LSB        19
`define ATTR_PERM_LSB       24
`define ATTR_XN_BIT         28
`define ATTR_WMASK          32'h173F_FF3F
`define ATTR_RESET          32'h0000_0000
`define SIZE_MIN            5'h04
`define SIZE_SUBREGIONS     5'h07

// ----------------------------------------
// system control space
// ----------------------------------------
`define SCS_FIRST           32'hE000_E000
`define SCS_LAST            32'hE000_EFFF

`endif

//--- inc/rpu_pkg.sv
// types shared by the region protection unit
// assumes nothing beyond a SystemVerilog compiler
package rpu_pkg;
   typedef logic [2:0] region_idx_t;
   typedef enum logic [1:0] {perm_none, perm_read, perm_rw} perm_t;
endpackage

//--- hw/region_match.sv
// address match of one protection region, subregion mask included
// assumes base held from bit 5 upward and a size field of five bits
`timescale 1ns/10ps
`default_nettype none
module region_match
   import rpu_pkg::*;
(
   // region programming
   input  wire logic [26:0] base,
   input  wire logic [4:0]  size,
   input  wire logic [7:0]  subregion_disable_mask,
   input  wire logic        enable,
   // address under test
   input  wire logic [31:0] addr,
   // result
   output logic             hit
);
`include "rpu_consts.svh"

   logic [5:0]  size_n;
   logic [5:0]  sub_shift;
   logic [31:0] hi_mask;
   logic [2:0]  sub_idx;
   logic        in_range;
   logic        sub_on;

   // ----------------------------------------
   // range and subregion
   // ----------------------------------------
   assign size_n    = 6'(size) + 6'h01;
   assign sub_shift = size_n - 6'h03;
   // a 4 GB region shifts the mask out entirely, so the base has no effect
   assign hi_mask   = 32'hFFFF_FFFF << size_n;
   assign in_range  = ((addr ^ {base, 5'h00}) & hi_mask) == 32'h0000_0000;
   // top three bits inside the region pick one of eight subregions
   assign sub_idx   = 3'(addr >> sub_shift);
   // small regions have no subregions, mask ignored there
   assign sub_on    = (size < `SIZE_SUBREGIONS) || !subregion_disable_mask[sub_idx];
   assign hit       = enable && (size >= `SIZE_MIN) && in_range && sub_on;

endmodule
`default_nettype wire

//--- verif/core_access_model.sv
// core side model: issues one checked access at a time, waits for the answer
// assumes chk_done comes back a cycle after the request is taken
`timescale 1ns/10ps
`default_nettype none
module core_access_model (
   // clock
   input  wire logic        clk_sys,
   // request, kind is {priv, fetch, write, vector, escalated}
   output logic             chk_valid,
   output logic [31:0]      chk_addr,
   output logic [4:0]       chk_kind,
   // answer
   input  wire logic        chk_done
);
   initial begin
      chk_valid = 1'b0;
      chk_addr  = 32'h0000_0000;
      chk_kind  = 5'h00;
   end

   // ----------------------------------------
   // one access, bounded wait
   // ----------------------------------------
   task automatic issue(input logic [31:0] a, input logic [4:0] k, output logic ok);
      int n;
      @(posedge clk_sys);
      chk_valid <= 1'b1;
      chk_addr  <= a;
      chk_kind  <= k;
      @(posedge clk_sys);
      chk_valid <= 1'b0;
      // idle bus shows garbage so a stale address is never trusted
      chk_addr  <= ~a;
      chk_kind  <= ~k;
      #1;
      for (n = 0; n < 4 && chk_done !== 1'b1; n++) begin
         @(posedge clk_sys);
         #1;
      end
      ok = (n < 4);
   endtask
endmodule
`default_nettype wire

//--- verif/region_protection_unit_regs_bench.sv
// bench for the region protection unit: register tasks and checked accesses
// assumes the core model file and the package are compiled first
`timescale 1ns/10ps
`default_nettype none
module region_protection_unit_regs_bench;
   import rpu_pkg::*;
   logic        clk_sys, rst, reg_wr, reg_rd, reg_rvalid, chk_valid, chk_done;
   logic        chk_fault, chk_hit, chk_strong_order, fault_iaccess, fault_daccess;
   logic [7:0]  reg_addr;
   logic [3:0]  reg_be;
   logic [31:0] reg_wdata, reg_rdata, chk_addr, fault_addr;
   logic [4:0]  chk_kind;
   logic [1:0]  fault_clear;
   logic [5:0]  chk_attr;
   region_idx_t chk_region;
   int          err_total, n_compared;
   localparam logic [4:0] K_UR = 5'h00, K_UW = 5'h04, K_PR = 5'h10, K_PW = 5'h14;
   localparam logic [4:0] K_PF = 5'h18, K_UV = 5'h02, K_PE = 5'h11;

   region_protection_unit_regs region_protection_unit_regs_i (
      .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chk_valid(chk_valid),
      .chk_addr(chk_addr), .chk_priv(chk_kind[4]), .chk_fetch(chk_kind[3]),
      .chk_write(chk_kind[2]), .chk_vector(chk_kind[1]), .chk_escalated(chk_kind[0]),
      .chk_done(chk_done), .chk_fault(chk_fault), .chk_hit(chk_hit),
      .chk_region(chk_region), .chk_attr(chk_attr), .chk_strong_order(chk_strong_order),
      .fault_clear(fault_clear), .fault_iaccess(fault_iaccess),
      .fault_daccess(fault_daccess), .fault_addr(fault_addr));

   core_access_model core_access_model_i (
      .clk_sys(clk_sys), .chk_valid(chk_valid), .chk_addr(chk_addr),
      .chk_kind(chk_kind), .chk_done(chk_done));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("errors %0d compares %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_be    <= be;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      int n;
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) begin
         @(posedge clk_sys);
         #1;
      end
      if (n == 4) begin
         err_total++;
         stop_test();
      end
      check(reg_rdata, exp);
   endtask

   // result seen as {fault, hit, region, strong order}, masked
   task automatic acc(input logic [31:0] a, input logic [4:0] k, input logic [5:0] exp,
                      input logic [5:0] m = 6'h3F);
      logic ok;
      core_access_model_i.issue(a, k, ok);
      if (!ok) begin
         err_total++;
         stop_test();
      end
      check({chk_fault, chk_hit, chk_region, chk_strong_order} & m, exp);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      err_total   = 0;
      n_compared  = 0;
      rst         = 1'b1;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      reg_addr    = 8'h00;
      reg_be      = 4'hF;
      reg_wdata   = 32'h0000_0000;
      fault_clear = 2'h0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      rd(8'h00, 32'h0000_0800);
      rd(8'h04, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      rd(8'h1C, 32'h0000_0000);
      acc(32'h2000_0000, K_UW, 6'h00);
      wr(8'h04, 4'hF, 32'h0000_0004); // handler bit left clear
      acc(32'h2000_0000, K_UR, 6'h00);
      wr(8'h0C, 4'hF, 32'h2000_0013);
      rd(8'h0C, 32'h2000_0003);
      rd(8'h08, 32'h0000_0003);
      wr(8'h0C, 4'hF, 32'h4000_0005);
      rd(8'h08, 32'h0000_0003);
      rd(8'h0C, 32'h4000_0003);
      wr(8'h0C, 4'hF, 32'h2000_0003);
      wr(8'h08, 4'hF, 32'h0000_000B);
      rd(8'h08, 32'h0000_0003);
      // region 3: 1 KB rw, subregion 1 off, then no-execute by halfword
      wr(8'h10, 4'hF, 32'h0300_0213);
      wr(8'h10, 4'hC, 32'h1300_0000);
      rd(8'h10, 32'h1300_0213);
      wr(8'h04, 4'hF, 32'h0000_0001);
      acc(32'h2000_0000, K_PF, 6'h36);
      acc(32'h2000_0010, K_UW, 6'h16);
      acc(32'h2000_0090, K_UR, 6'h20);
      check({fault_iaccess, fault_daccess}, 2'h3);
      check(fault_addr, 32'h2000_0090);
      @(posedge clk_sys);
      fault_clear <= 2'h3;
      @(posedge clk_sys);
      fault_clear <= 2'h0;
      @(posedge clk_sys);
      #1;
      check({fault_iaccess, fault_daccess}, 2'h0);
      acc(32'h2000_0400, K_PR, 6'h20);
      acc(32'hE000_E010, K_UW, 6'h01, 6'h21);
      acc(32'hE000_E010, K_PF, 6'h21, 6'h21);
      acc(32'h3000_0000, K_UV, 6'h00);
      acc(32'h3000_0000, K_PE, 6'h00);
      wr(8'h04, 4'hF, 32'h0000_0003); // enable set with handler bit
      acc(32'h3000_0000, K_PE, 6'h20);
      wr(8'h04, 4'hF, 32'h0000_0005);
      acc(32'h3000_0000, K_PR, 6'h00);
      acc(32'h3000_0000, K_UR, 6'h20);
      // region 5: 32 bytes read-only over the start of region 3, mask kept zero
      wr(8'h0C, 4'hF, 32'h2000_0015);
      wr(8'h10, 4'hF, 32'h0600_0009);
      acc(32'h2000_0004, K_PW, 6'h3A);
      acc(32'h2000_0020, K_UW, 6'h16);
      // region 7: whole map, base ignored
      wr(8'h0C, 4'hF, 32'h8000_0017);
      wr(8'h10, 4'hF, 32'h0306_003F);
      acc(32'h0000_1000, K_UR, 6'h1E);
      check(chk_attr, 6'h06);
      stop_test();
   end
endmodule
`default_nettype wire
